// *** bench/serial_far_end.sv ***
`timescale 1ns/100ps
module serial_far_end (
    // Clock
    input  wire logic clk,
    // Line towards our receiver
    output logic      line_out,
    // Line from our transmitter
    input  wire logic line_in
);
    // ==========================================================
    // Frame format shared with the bench
    int         bit_clks = 32;
    int         nbits    = 8;
    logic [9:0] rx_q[$];
    logic [9:0] acc;

    initial line_out = 1'b1;

    // ==========================================================
    // Remote transmitter, bit period in clk cycles
    task automatic send(input logic [8:0] data, input logic stop_lvl, input int clks);
        line_out = 1'b0;
        repeat (clks) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            line_out = data[i];
            repeat (clks) @(negedge clk);
        end
        line_out = stop_lvl;
        repeat (clks) @(negedge clk);
        line_out = 1'b1;
        repeat (clks) @(negedge clk);
    endtask

    // ==========================================================
    // Remote receiver, mid-bit sampling, stop kept in the bit above the data
    always begin
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge clk);
        if (line_in === 1'b0) begin
            acc = '0;
            for (int i = 0; i <= nbits; i++) begin
                repeat (bit_clks) @(posedge clk);
                acc[i] = line_in;
            end
            rx_q.push_back(acc);
        end
    end
endmodule // serial_far_end

// *** bench/tb_async_serial_rx_tx_sampling.sv ***
`timescale 1ns/100ps
module tb_async_serial_rx_tx_sampling;
    import serial_pkg::*;

    // ==========================================================
    // Signals
    logic              clk, nrst, tx_en, rx_en, nine_bit;
    logic [DIV_W-1:0]  baud_div;
    logic              tx_out, tx_oe, rx_pin, tx_valid, tx_ready, tx_busy;
    logic [DATA_W-1:0] tx_data, rx_data;
    logic              rx_noise, rx_frame_err, rx_valid, rx_ready, rx_overrun, rx_line_idle;
    int                n_fail, n_tests, n_ovr, exp_ovr;
    logic [10:0]       exp_q[$];
    // Pull-up on the released transmit wire
    wire               tx_line = tx_oe ? tx_out : 1'b1;

    serial_port u_dut (
        .clk(clk), .nrst(nrst), .tx_en(tx_en), .rx_en(rx_en), .nine_bit(nine_bit),
        .baud_div(baud_div), .tx_out(tx_out), .tx_oe(tx_oe), .rx_pin(rx_pin),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_noise(rx_noise), .rx_frame_err(rx_frame_err), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .rx_line_idle(rx_line_idle),
        .tx_busy(tx_busy)
    );

    serial_far_end u_far (
        .clk(clk),
        .line_out(rx_pin),
        .line_in(tx_line)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Sampled away from the launching edge
    always @(negedge clk) if (rx_overrun === 1'b1) n_ovr++;

    // ==========================================================
    // Comparison and closing
    task automatic check_word(input string what, input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input string what, input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Transmit side
    task automatic tx_send(input logic [8:0] d);
        int n;
        n = 0;
        tx_data  = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
        check_bit("start bit", tx_out, 1'b0);
        check_bit("busy", tx_busy, 1'b1);
    endtask

    task automatic tx_frame(input logic [8:0] d);
        int n;
        logic [9:0] exp;
        n   = 0;
        exp = nine_bit ? {1'b1, d} : {2'b01, d[7:0]};
        tx_send(d);
        while (u_far.rx_q.size() == 0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check_word("tx frame", {1'b0, u_far.rx_q.size() > 0 ? u_far.rx_q.pop_front() : 10'h3ff},
                   {1'b0, exp});
        repeat (40) @(negedge clk);
        check_bit("tx idle level", tx_out, 1'b1);
        check_bit("tx ready again", tx_ready, 1'b1);
    endtask

    // ==========================================================
    // Receive side with queue model
    task automatic rx_frame(input logic [8:0] d, input logic stop, input int clks);
        logic [8:0] dm;
        dm = nine_bit ? d : {1'b0, d[7:0]};
        u_far.send(d, stop, clks);
        if (rx_en === 1'b1) begin
            if (exp_q.size() < FIFO_DEPTH)
                exp_q.push_back({~stop, 1'b0, dm});
            else
                exp_ovr++;
        end
    endtask

    task automatic rx_pop;
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check_word("rx word", {rx_frame_err, rx_noise, rx_data}, exp_q.size() > 0 ? exp_q.pop_front() : 11'h7ff);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask

    // ==========================================================
    // Watchdog, about four times the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    // ==========================================================
    // Tests
    initial begin
        {nrst, tx_en, rx_en, nine_bit, tx_valid, rx_ready} = 6'h00;
        baud_div = 16'h0002;
        tx_data  = '0;
        {n_fail, n_tests, n_ovr, exp_ovr} = {4{32'sd0}};
        void'($urandom(32'h5c91));
        repeat (5) @(negedge clk);
        check_bit("reset tx level", tx_out, 1'b1);
        check_bit("reset tx released", tx_oe, 1'b0);
        nrst  = 1'b1;
        tx_en = 1'b1;
        rx_en = 1'b1;
        repeat (4) @(negedge clk);
        check_bit("tx driven", tx_oe, 1'b1);
        check_bit("line idle", rx_line_idle, 1'b1);
        $display("test reset done");

        for (int nb = 0; nb < 2; nb++) begin
            nine_bit    = nb[0];
            u_far.nbits = 8 + nb;
            tx_frame(9'h000);
            tx_frame(9'h1ff);
            repeat (3) tx_frame(9'($urandom));
            repeat (3) rx_frame(9'($urandom), 1'b1, 32);
            repeat (3) rx_pop();
        end
        nine_bit    = 1'b0;
        u_far.nbits = 8;
        $display("test frames done");

        rx_frame(9'($urandom), 1'b0, 32);
        rx_pop();
        $display("test framing done");

        rx_frame(9'h055, 1'b1, 34);
        rx_pop();
        $display("test slow sender done");

        rx_en = 1'b0;
        repeat (4) @(negedge clk);
        check_bit("idle while off", rx_line_idle, 1'b0);
        rx_frame(9'($urandom), 1'b1, 32);
        check_bit("nothing received", rx_valid, 1'b0);
        rx_en = 1'b1;
        $display("test receiver off done");

        repeat (FIFO_DEPTH + 1) rx_frame(9'($urandom), 1'b1, 32);
        repeat (4) @(negedge clk);
        check_word("overruns", 11'(n_ovr), 11'(exp_ovr));
        repeat (FIFO_DEPTH) rx_pop();
        check_bit("drained", rx_valid, 1'b0);
        $display("test fill done");

        tx_send(9'($urandom));
        repeat (40) @(negedge clk);
        tx_en = 1'b0;
        @(negedge clk);
        check_bit("tx released", tx_oe, 1'b0);
        repeat (400) @(negedge clk);
        u_far.rx_q.delete();
        tx_en = 1'b1;
        $display("test tx disable done");
        complete_run();
    end
endmodule // tb_async_serial_rx_tx_sampling

// *** core/char_fifo.sv ***
`timescale 1ns/100ps
module char_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;

    assign in_ready  = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
    assign out_valid = (wr_ff != rd_ff);
    assign out_data  = mem[rd_ff[AW-1:0]];

    // ==========================================================
    // Storage and pointers
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ff <= '0;
        end else if (in_valid && in_ready) begin
            wr_ff <= wr_ff + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ff <= '0;
        end else if (out_valid && out_ready) begin
            rd_ff <= rd_ff + (AW+1)'(1);
        end
    end

endmodule // char_fifo

// *** core/serial_pkg.sv ***
package serial_pkg;

    // ==========================================================
    // Oversampling
    localparam int unsigned OVS_TICKS   = 16;
    localparam logic [3:0]  RT_LAST     = 4'hf;
    localparam logic [3:0]  RT_SMP_A    = 4'h7;
    localparam logic [3:0]  RT_SMP_B    = 4'h8;
    localparam logic [3:0]  RT_SMP_C    = 4'h9;
    localparam logic [3:0]  RT_LATE     = 4'h8;

    // ==========================================================
    // Frame layout
    localparam logic [3:0]  STOP_IDX8   = 4'h9;
    localparam logic [3:0]  STOP_IDX9   = 4'ha;
    localparam int unsigned STOP_START8 = 9 * OVS_TICKS + 7;
    localparam int unsigned STOP_START9 = 10 * OVS_TICKS + 7;

    // ==========================================================
    // Widths, depths, reset values
    localparam int unsigned DIV_W       = 16;
    localparam int unsigned DATA_W      = 9;
    localparam int unsigned RX_WORD_W   = 11;
    localparam int unsigned NOISE_POS   = 9;
    localparam int unsigned FRAME_POS   = 10;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic [15:0] DIV_RST     = 16'h0000;
    localparam logic [3:0]  CNT_RST     = 4'h0;
    localparam logic [7:0]  ELAPSED_RST = 8'h00;

    typedef enum {RX_IDLE, RX_BUSY} rx_state_t;
    typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

// *** core/serial_port.sv ***
`timescale 1ns/100ps
module serial_port (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // Configuration
    input  wire logic                        tx_en,
    input  wire logic                        rx_en,
    input  wire logic                        nine_bit,
    input  wire logic [serial_pkg::DIV_W-1:0] baud_div,
    // Pins
    output logic                             tx_out,
    output logic                             tx_oe,
    input  wire logic                        rx_pin,
    // Transmit stream
    input  wire logic [serial_pkg::DATA_W-1:0] tx_data,
    input  wire logic                        tx_valid,
    output logic                             tx_ready,
    // Receive stream
    output logic [serial_pkg::DATA_W-1:0]    rx_data,
    output logic                             rx_noise,
    output logic                             rx_frame_err,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    // Status
    output logic                             rx_overrun,
    output logic                             rx_line_idle,
    output logic                             tx_busy
);
    import serial_pkg::*;

    logic [DIV_W-1:0]     div_ff;
    logic                 tick;
    tx_state_t            tx_state_ff;
    logic [3:0]           tx_rt_ff;
    logic [3:0]           tx_bit_ff;
    logic [10:0]          tx_shift_ff;
    logic                 tx_out_ff;
    logic                 tx_oe_ff;
    logic [3:0]           tx_last;
    logic                 rx_s1_ff;
    logic                 rx_s2_ff;
    logic                 prev_ff;
    rx_state_t            rx_state_ff;
    logic [3:0]           rt_ff;
    logic [3:0]           bit_ff;
    logic [1:0]           smp_ff;
    logic [DATA_W-1:0]    data_ff;
    logic                 noise_acc_ff;
    logic                 push_ff;
    logic [RX_WORD_W-1:0] push_word_ff;
    logic                 push_ready;
    logic                 overrun_ff;
    logic                 idle_ff;
    logic [RX_WORD_W-1:0] pop_word;
    logic [2:0]           cur_smp;
    logic [3:0]           stop_idx;
    logic                 fall;
    logic                 eval;
    logic [7:0]           elapsed_ff;
    logic                 resynced_ff;

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic mixed3(input logic [2:0] s);
        mixed3 = (s != 3'h0) && (s != 3'h7);
    endfunction

    // ==========================================================
    // Oversampling tick
    assign tick = (div_ff == DIV_RST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff <= DIV_RST;
        end else if (tick) begin
            div_ff <= baud_div - DIV_W'(1);
        end else begin
            div_ff <= div_ff - DIV_W'(1);
        end
    end

    // ==========================================================
    // Transmitter
    assign tx_last  = nine_bit ? STOP_IDX9 : STOP_IDX8;
    assign tx_ready = tx_en && (tx_state_ff == TX_IDLE);
    assign tx_out   = tx_out_ff;
    assign tx_oe    = tx_oe_ff;
    assign tx_busy  = (tx_state_ff == TX_SHIFT);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_oe_ff <= 1'b0;
        end else begin
            tx_oe_ff <= tx_en;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_ff <= TX_IDLE;
            tx_rt_ff    <= CNT_RST;
            tx_bit_ff   <= CNT_RST;
            tx_shift_ff <= '1;
            tx_out_ff   <= 1'b1;
        end else if (!tx_en) begin
            tx_state_ff <= TX_IDLE;
            tx_out_ff   <= 1'b1;
        end else begin
            unique case (tx_state_ff)
                TX_IDLE: begin
                    tx_out_ff <= 1'b1;
                    if (tx_valid) begin
                        tx_state_ff <= TX_SHIFT;
                        tx_rt_ff    <= CNT_RST;
                        tx_bit_ff   <= CNT_RST;
                        tx_shift_ff <= nine_bit ? {1'b1, tx_data, 1'b0} : {2'b11, tx_data[7:0], 1'b0};
                        tx_out_ff   <= 1'b0;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        tx_rt_ff <= tx_rt_ff + 4'h1;
                        if (tx_rt_ff == RT_LAST) begin
                            if (tx_bit_ff == tx_last) begin
                                tx_state_ff <= TX_IDLE;
                                tx_out_ff   <= 1'b1;
                            end else begin
                                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                                tx_out_ff   <= tx_shift_ff[1];
                                tx_bit_ff   <= tx_bit_ff + 4'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Receive pin synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // ==========================================================
    // Receiver
    assign cur_smp  = {smp_ff, rx_s2_ff};
    assign stop_idx = nine_bit ? STOP_IDX9 : STOP_IDX8;
    assign fall     = prev_ff && !rx_s2_ff;
    assign eval     = tick && (rx_state_ff == RX_BUSY) && (rt_ff == RT_SMP_C);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_ff <= 1'b1;
        end else if (!rx_en) begin
            prev_ff <= 1'b1;
        end else if (tick) begin
            prev_ff <= rx_s2_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_state_ff  <= RX_IDLE;
            rt_ff        <= CNT_RST;
            bit_ff       <= CNT_RST;
            smp_ff       <= 2'h3;
            data_ff      <= '0;
            noise_acc_ff <= 1'b0;
            push_ff      <= 1'b0;
            push_word_ff <= '0;
        end else begin
            push_ff <= 1'b0;
            if (!rx_en) begin
                rx_state_ff <= RX_IDLE;
            end else if (tick) begin
                unique case (rx_state_ff)
                    RX_IDLE: begin
                        if (fall) begin
                            rx_state_ff  <= RX_BUSY;
                            rt_ff        <= CNT_RST;
                            bit_ff       <= CNT_RST;
                            data_ff      <= '0;
                            noise_acc_ff <= 1'b0;
                        end
                    end
                    RX_BUSY: begin
                        if (rt_ff == RT_SMP_A || rt_ff == RT_SMP_B) begin
                            smp_ff <= cur_smp[1:0];
                        end
                        if (rt_ff == RT_SMP_C) begin
                            if (bit_ff == CNT_RST) begin
                                if (maj3(cur_smp)) begin
                                    rx_state_ff <= RX_IDLE;
                                end
                            end else if (bit_ff == stop_idx) begin
                                push_ff      <= 1'b1;
                                push_word_ff <= {!maj3(cur_smp), noise_acc_ff | mixed3(cur_smp), data_ff};
                                rx_state_ff  <= RX_IDLE;
                            end else begin
                                data_ff[bit_ff - 4'h1] <= maj3(cur_smp);
                                noise_acc_ff           <= noise_acc_ff | mixed3(cur_smp);
                            end
                        end
                        if (rt_ff != RT_SMP_C && fall && bit_ff != CNT_RST) begin
                            rt_ff <= CNT_RST;
                            if (rt_ff >= RT_LATE) begin
                                bit_ff <= bit_ff + 4'h1;
                            end
                        end else begin
                            rt_ff <= rt_ff + 4'h1;
                            if (rt_ff == RT_LAST) begin
                                bit_ff <= bit_ff + 4'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idle_ff <= 1'b0;
        end else begin
            idle_ff <= rx_en && rx_s2_ff && (rx_state_ff == RX_IDLE);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= push_ff && !push_ready;
        end
    end

    assign rx_line_idle = idle_ff;
    assign rx_overrun   = overrun_ff;

    // ==========================================================
    // Receive buffer
    char_fifo #(
        .WIDTH (RX_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   (push_word_ff),
        .in_valid  (push_ff),
        .in_ready  (push_ready),
        .out_data  (pop_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign rx_data      = pop_word[DATA_W-1:0];
    assign rx_noise     = pop_word[NOISE_POS];
    assign rx_frame_err = pop_word[FRAME_POS];

    // ==========================================================
    // Checks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            elapsed_ff  <= ELAPSED_RST;
            resynced_ff <= 1'b0;
        end else if (tick && rx_state_ff == RX_IDLE) begin
            elapsed_ff  <= ELAPSED_RST;
            resynced_ff <= 1'b0;
        end else if (tick) begin
            elapsed_ff  <= elapsed_ff + 8'h01;
            resynced_ff <= resynced_ff | (fall && bit_ff != CNT_RST && rt_ff != RT_SMP_C);
        end
    end

    property p_tx_idle_high;
        @(posedge clk) disable iff (!nrst)
        (tx_en && tx_state_ff == TX_IDLE && !tx_valid) |=> tx_out;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) else $error("tx pin not high while idle");

    property p_tx_release;
        @(posedge clk) disable iff (!nrst)
        !tx_en |=> !tx_oe;
    endproperty
    a_tx_release: assert property (p_tx_release) else $error("tx pin driven while disabled");

    property p_line_idle;
        @(posedge clk) disable iff (!nrst)
        (rx_en && rx_s2_ff && rx_state_ff == RX_IDLE) |=> rx_line_idle;
    endproperty
    a_line_idle: assert property (p_line_idle) else $error("idle line not reported");

    property p_rx_ignored;
        @(posedge clk) disable iff (!nrst)
        !rx_en |=> (rx_state_ff == RX_IDLE) && !push_ff;
    endproperty
    a_rx_ignored: assert property (p_rx_ignored) else $error("disabled receiver reacted to pin");

    property p_noise;
        @(posedge clk) disable iff (!nrst)
        (eval && bit_ff == stop_idx && mixed3(cur_smp)) |=> push_ff && push_word_ff[NOISE_POS];
    endproperty
    a_noise: assert property (p_noise) else $error("mixed stop samples not flagged as noise");

    property p_framing;
        @(posedge clk) disable iff (!nrst)
        (eval && bit_ff == stop_idx) |=> push_word_ff[FRAME_POS] == !maj3($past(cur_smp));
    endproperty
    a_framing: assert property (p_framing) else $error("framing flag disagrees with stop majority");

    property p_resync;
        @(posedge clk) disable iff (!nrst)
        (tick && rx_en && rx_state_ff == RX_BUSY && fall && bit_ff != CNT_RST && rt_ff != RT_SMP_C)
            |=> rt_ff == CNT_RST;
    endproperty
    a_resync: assert property (p_resync) else $error("tick counter not realigned on edge");

    property p_stop_time;
        @(posedge clk) disable iff (!nrst)
        (tick && rx_state_ff == RX_BUSY && bit_ff == stop_idx && rt_ff == RT_SMP_A && !resynced_ff)
            |-> elapsed_ff == (nine_bit ? 8'(STOP_START9) : 8'(STOP_START8));
    endproperty
    a_stop_time: assert property (p_stop_time) else $error("stop sampling at wrong tick");

    property p_start;
        @(posedge clk) disable iff (!nrst)
        (tick && rx_en && rx_state_ff == RX_IDLE && fall) |=> rx_state_ff == RX_BUSY;
    endproperty
    a_start: assert property (p_start) else $error("start edge not taken");

    property p_cov_good;
        @(posedge clk) disable iff (!nrst)
        push_ff && !push_word_ff[NOISE_POS] && !push_word_ff[FRAME_POS];
    endproperty
    c_cov_good: cover property (p_cov_good);

    property p_cov_frame;
        @(posedge clk) disable iff (!nrst)
        push_ff && push_word_ff[FRAME_POS];
    endproperty
    c_cov_frame: cover property (p_cov_frame);

    property p_cov_overrun;
        @(posedge clk) disable iff (!nrst)
        overrun_ff;
    endproperty
    c_cov_overrun: cover property (p_cov_overrun);

endmodule // serial_port
